// ===== sdcf_config_header.sv
/*
 * Configuration header of the SD host function: identifiers, bus control,
 * slot window bases, function control, subsystem alias and test setup.
 * Assumes a single-cycle configuration port already qualified by the host
 * bridge, clocked on sys_clk, with byte enables on a 32-bit dword.
 */
`timescale 1ns/1ns
module sdcf_config_header #(
    parameter logic [15:0] MAKER_ID = 16'h1234,  // Arbitrary value.
    parameter logic [15:0] PART_ID  = 16'h5678   // Arbitrary value.
) (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        global_reset_n,
    input  wire logic        cfgSel,
    input  wire logic [2:0]  cfgFunc,
    input  wire logic        cfgWrite,
    input  wire logic [7:0]  cfgAddr,
    input  wire logic [3:0]  cfgByteEn,
    input  wire logic [31:0] cfgWrData,
    input  wire logic        intSelStrap,
    input  wire logic        intRequest,
    input  wire logic        parityErrEvent,
    input  wire logic        addrParityEvent,
    input  wire logic        dmaWantBus,
    input  wire logic        memCycleHit,
    output logic [31:0]      cfgRdData,
    output logic             cfgAck,
    output logic [3:0]       intxAssert,
    output logic             systemErrDrive,
    output logic             parityErrDrive,
    output logic             initiatorGo,
    output logic             memClaim,
    output logic [31:0]      slotBase1,
    output logic [31:0]      slotBase2,
    output logic [2:0]       pllSetN,
    output logic [4:0]       pllSetM,
    output logic             diagShorten
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage.
    logic [15:0] control_reg;     // Bus control word, stored bits only.
    logic [7:0]  funcCtrl_reg;    // Function control, global reset only.
    logic [31:0] subsys_reg;      // Subsystem identifiers, global reset only.
    logic [31:0] testPll_reg;     // Test and PLL setup, global reset only.
    logic [31:0] base1_reg;       // Second slot window base.
    logic [31:0] base2_reg;       // Third slot window base.
    logic        grstMeta_reg;    // Global reset synchroniser, first stage.
    logic        grstSync_reg;    // Global reset synchroniser, second stage.
    logic [2:0]  strapMeta_reg;   // Pin inputs, first stage.
    logic [2:0]  strapSync_reg;   // Pin inputs, second stage.
    logic        hit;             // Access addressed to this function.
    logic        wrHit;           // Write addressed to this function.
    logic [31:0] rdNext;          // Read data for the current access.
    logic [31:0] ctrlMerged;      // Bus control write merge, full dword.
    logic [31:0] funcMerged;      // Function control write merge, full dword.

    // Applies byte enables and a writable mask to merge write data.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be, input logic [31:0] wm);
        logic [31:0] lane;
        lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
        merge = (old & ~lane) | (nw & lane);
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the incoming access.
    assign hit   = cfgSel && (cfgFunc == sdcf_pkg::FUNC_NUM);
    assign wrHit = hit && cfgWrite;

    // Merges are formed at full width here so the narrow registers can take
    // an explicit slice; a function result cannot be part-selected in place.
    assign ctrlMerged = merge({16'h0000, control_reg}, cfgWrData, cfgByteEn,
                              {16'h0000, sdcf_pkg::CONTROL_WMASK});
    assign funcMerged = merge({24'h000000, funcCtrl_reg}, cfgWrData, cfgByteEn,
                              {24'h000000, sdcf_pkg::FUNC_CTRL_WMASK});

    // The global reset pin and straps come from outside the clock domain.
    // A glitch on the pin must not half-clear the sticky bits, so it is synced.
    always_ff @(posedge sys_clk)
    begin
        grstMeta_reg  <= ~global_reset_n;
        grstSync_reg  <= grstMeta_reg;
        strapMeta_reg <= {intSelStrap, parityErrEvent, addrParityEvent};
        strapSync_reg <= strapMeta_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus control; only the five live bits ever store a one.
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            control_reg <= sdcf_pkg::CONTROL_RST;
        end
        else if (wrHit && cfgAddr == sdcf_pkg::OFF_CONTROL)
        begin
            // Hardwired bits never store, so they read zero.
            control_reg <= ctrlMerged[15:0];
        end
    end

    // Slot window bases follow the ordinary bus reset.
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            base1_reg <= sdcf_pkg::SLOT_BASE_RST;
            base2_reg <= sdcf_pkg::SLOT_BASE_RST;
        end
        else if (wrHit && cfgAddr == sdcf_pkg::OFF_SLOT1_BASE)
        begin
            base1_reg <= merge(base1_reg, cfgWrData, cfgByteEn, 32'hffff_ffff);
        end
        else if (wrHit && cfgAddr == sdcf_pkg::OFF_SLOT2_BASE)
        begin
            base2_reg <= merge(base2_reg, cfgWrData, cfgByteEn, 32'hffff_ffff);
        end
    end

    // Sticky registers ignore srst so a bus reset keeps the board setup.
    always_ff @(posedge sys_clk)
    begin
        if (grstSync_reg)
        begin
            funcCtrl_reg <= sdcf_pkg::FUNC_CTRL_RST;
            subsys_reg   <= sdcf_pkg::SUBSYS_RST;
            testPll_reg  <= sdcf_pkg::TEST_PLL_RST;
        end
        else if (wrHit && cfgAddr == sdcf_pkg::OFF_FUNC_CTRL)
        begin
            funcCtrl_reg <= funcMerged[7:0];
        end
        else if (wrHit && cfgAddr == sdcf_pkg::OFF_SUBSYS_ALIAS)
        begin
            subsys_reg <= merge(subsys_reg, cfgWrData, cfgByteEn, 32'hffff_ffff);
        end
        else if (wrHit && cfgAddr == sdcf_pkg::OFF_TEST_PLL)
        begin
            testPll_reg <= merge(testPll_reg, cfgWrData, cfgByteEn,
                                 sdcf_pkg::TEST_PLL_WMASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; anything not decoded answers zero.
    always_comb
    begin
        rdNext = 32'h0000_0000;
        if (cfgAddr == sdcf_pkg::OFF_IDENT)
        begin
            rdNext = {PART_ID, MAKER_ID};
        end
        else if (cfgAddr == sdcf_pkg::OFF_CONTROL)
        begin
            rdNext = {16'h0000, control_reg};
        end
        else if (cfgAddr == sdcf_pkg::OFF_SLOT1_BASE)
        begin
            rdNext = base1_reg;
        end
        else if (cfgAddr == sdcf_pkg::OFF_SLOT2_BASE)
        begin
            rdNext = base2_reg;
        end
        else if (cfgAddr == sdcf_pkg::OFF_SUBSYS || cfgAddr == sdcf_pkg::OFF_SUBSYS_ALIAS)
        begin
            rdNext = subsys_reg;
        end
        else if (cfgAddr == sdcf_pkg::OFF_FUNC_CTRL)
        begin
            rdNext = {24'h000000, funcCtrl_reg};
        end
        else if (cfgAddr == sdcf_pkg::OFF_TEST_PLL)
        begin
            rdNext = testPll_reg;
        end
    end

    // Answer one cycle after the access; read data only on a read hit.
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            cfgAck    <= 1'b0;
            cfgRdData <= 32'h0000_0000;
        end
        else
        begin
            cfgAck    <= hit;
            cfgRdData <= (hit && !cfgWrite) ? rdNext : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enables to the rest of the function, all registered.
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            intxAssert     <= 4'h0;
            systemErrDrive <= 1'b0;
            parityErrDrive <= 1'b0;
            initiatorGo    <= 1'b0;
            memClaim       <= 1'b0;
        end
        else
        begin
            intxAssert <= 4'h0;
            if (intRequest && !control_reg[sdcf_pkg::BIT_INT_DISABLE])
            begin
                // A strap forces line A; the field is ignored.
                if (strapSync_reg[2])
                begin
                    intxAssert <= 4'h1;
                end
                else
                begin
                    intxAssert <= 4'h1 << funcCtrl_reg[sdcf_pkg::INT_SEL_LSB +: 2];
                end
            end
            systemErrDrive <= strapSync_reg[0] && control_reg[sdcf_pkg::BIT_SERR_EN];
            parityErrDrive <= strapSync_reg[1] && control_reg[sdcf_pkg::BIT_PERR_EN];
            initiatorGo    <= dmaWantBus && control_reg[sdcf_pkg::BIT_MASTER_EN];
            memClaim       <= memCycleHit && control_reg[sdcf_pkg::BIT_MEM_EN];
        end
    end

    // Window bases and PLL settings go out registered.
    always_ff @(posedge sys_clk)
    begin
        slotBase1   <= base1_reg;
        slotBase2   <= base2_reg;
        pllSetN     <= testPll_reg[10:8];
        pllSetM     <= testPll_reg[4:0];
        diagShorten <= testPll_reg[16];
    end

endmodule : sdcf_config_header

// ===== sdcf_config_header_asserts.sv
/* Port checker for the SD function config header.
   Assumes it is bound onto sdcf_config_header. */
`timescale 1ns/1ns
module sdcf_hdr_asserts #(
    parameter logic [15:0] MAKER_ID = 16'h1234, // Arbitrary value.
    parameter logic [15:0] PART_ID  = 16'h5678  // Arbitrary value.
) (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        cfgSel,
    input wire logic [2:0]  cfgFunc,
    input wire logic        cfgWrite,
    input wire logic [7:0]  cfgAddr,
    input wire logic        intRequest,
    input wire logic        dmaWantBus,
    input wire logic        memCycleHit,
    input wire logic [31:0] cfgRdData,
    input wire logic        cfgAck,
    input wire logic [3:0]  intxAssert,
    input wire logic        initiatorGo,
    input wire logic        memClaim
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // A read taken by this function.
    wire rdHit = cfgSel && cfgFunc == 3'h4 && !cfgWrite;
    chk_ack_next: assert property (cfgSel && cfgFunc == 3'h4 |=> cfgAck)
        else $error("ack missing");
    chk_ack_foreign: assert property (!(cfgSel && cfgFunc == 3'h4) |=> !cfgAck)
        else $error("stray ack");
    chk_ident_read: assert property (rdHit && cfgAddr == 8'h00
        |=> cfgRdData == {PART_ID, MAKER_ID}) else $error("bad ident");
    chk_ctrl_zeros: assert property (rdHit && cfgAddr == 8'h04
        |=> (cfgRdData[15:0] & 16'hfab9) == 16'h0000) else $error("fixed bit set");
    chk_reserved_zero: assert property (rdHit && cfgAddr inside {[8'h1c:8'h28]}
        |=> cfgRdData == 32'h0000_0000) else $error("reserved nonzero");
    chk_master_gate: assert property (initiatorGo |-> $past(dmaWantBus))
        else $error("master without need");
    chk_mem_gate: assert property (memClaim |-> $past(memCycleHit))
        else $error("claim without hit");
    chk_intx_cause: assert property (intxAssert != 4'h0
        |-> $onehot(intxAssert) && $past(intRequest)) else $error("bad intx");
    cover property (rdHit && cfgAddr == 8'h04);
    cover property (initiatorGo && memClaim);
    cover property (intxAssert == 4'h8);
endmodule : sdcf_hdr_asserts
bind sdcf_config_header sdcf_hdr_asserts #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID))
    sdcf_hdr_asserts_i (.sys_clk(sys_clk), .srst(srst), .cfgSel(cfgSel),
    .cfgFunc(cfgFunc), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .intRequest(intRequest),
    .dmaWantBus(dmaWantBus), .memCycleHit(memCycleHit), .cfgRdData(cfgRdData),
    .cfgAck(cfgAck), .intxAssert(intxAssert), .initiatorGo(initiatorGo),
    .memClaim(memClaim));

// ===== sdcf_config_header_tb.sv
/* Self-checking bench for the config header.
   Assumes the host model drives every config cycle. */
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module sdcf_config_header_tb;
    logic sys_clk = 0, srst = 1, global_reset_n = 0, intSelStrap = 0, intRequest = 0;
    logic parityErrEvent = 0, addrParityEvent = 0, dmaWantBus = 0, memCycleHit = 0;
    logic cfgSel, cfgWrite, cfgAck, systemErrDrive, parityErrDrive, initiatorGo, memClaim;
    logic [2:0] cfgFunc;
    logic [7:0] cfgAddr;
    logic [3:0] cfgByteEn, intxAssert;
    logic [31:0] cfgWrData, cfgRdData, rd, slotBase1, slotBase2;
    logic [2:0] pllSetN;
    logic [4:0] pllSetM;
    logic diagShorten;
    int fail_count = 0;
    int total_checks = 0;
    always #4 sys_clk = ~sys_clk;
    sdcf_config_header #(.MAKER_ID(16'h1234), .PART_ID(16'h5678)) sdcf_config_header_i (
        .sys_clk(sys_clk), .srst(srst), .global_reset_n(global_reset_n), .cfgSel(cfgSel),
        .cfgFunc(cfgFunc), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
        .cfgWrData(cfgWrData), .intSelStrap(intSelStrap), .intRequest(intRequest),
        .parityErrEvent(parityErrEvent), .addrParityEvent(addrParityEvent),
        .dmaWantBus(dmaWantBus), .memCycleHit(memCycleHit), .cfgRdData(cfgRdData),
        .cfgAck(cfgAck), .intxAssert(intxAssert), .systemErrDrive(systemErrDrive),
        .parityErrDrive(parityErrDrive), .initiatorGo(initiatorGo), .memClaim(memClaim),
        .slotBase1(slotBase1), .slotBase2(slotBase2), .pllSetN(pllSetN),
        .pllSetM(pllSetM), .diagShorten(diagShorten));
    sdcf_host_model sdcf_host_model_i (.sys_clk(sys_clk), .cfgRdData(cfgRdData),
        .cfgAck(cfgAck), .cfgSel(cfgSel), .cfgFunc(cfgFunc), .cfgWrite(cfgWrite),
        .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData));
    task automatic tally_and_finish();
        if (fail_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    // Access to function four; a missing ack ends the run.
    task automatic acc(input logic [7:0] ad, input logic wr, input logic [3:0] be,
        input logic [31:0] wd);
        logic ok;
        sdcf_host_model_i.access(3'h4, wr, ad, be, wd, rd, ok);
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("ERROR %0t no ack", $time);
            tally_and_finish();
        end
    endtask : acc
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wt
    task automatic t_regs();
        acc(8'h00, 1, 4'hf, 32'hffff_ffff);
        acc(8'h00, 0, 4'hf, 0);
        `CHK(rd, 32'h5678_1234)
        acc(8'h04, 1, 4'h3, 32'h0000_ffff);
        acc(8'h04, 0, 4'hf, 0);
        `CHK(rd, 32'h0000_0546)
        acc(8'h1c, 1, 4'hf, 32'hffff_ffff);
        acc(8'h1c, 0, 4'hf, 0);
        `CHK(rd, 32'h0)
    endtask : t_regs
    // Window bases and the test register, read back and seen on the outputs.
    task automatic t_windows();
        acc(8'h90, 0, 4'hf, 0);
        `CHK(rd, 32'h0000_0105)
        `CHK({pllSetN, pllSetM, diagShorten}, {3'h1, 5'h05, 1'b0})
        acc(8'h90, 1, 4'hf, 32'hffff_ffff);
        acc(8'h90, 0, 4'hf, 0);
        `CHK(rd, 32'h0001_071f)
        `CHK({pllSetN, pllSetM, diagShorten}, {3'h7, 5'h1f, 1'b1})
        acc(8'h14, 1, 4'hf, 32'hdead_beef);
        acc(8'h18, 1, 4'h3, 32'h1234_abcd);
        acc(8'h14, 0, 4'hf, 0);
        `CHK(rd, 32'hdead_beef)
        acc(8'h18, 0, 4'hf, 0);
        `CHK(rd, 32'h0000_abcd)
        `CHK({slotBase1, slotBase2}, {32'hdead_beef, 32'h0000_abcd})
    endtask : t_windows
    task automatic t_gates();
        logic ok;
        acc(8'h04, 1, 4'h3, 32'h0000_0006);
        {dmaWantBus, memCycleHit} = 2'b11;
        wt(2);
        `CHK({initiatorGo, memClaim}, 2'b11)
        acc(8'h04, 1, 4'h3, 32'h0000_0002);
        wt(2);
        `CHK({initiatorGo, memClaim}, 2'b01)
        acc(8'h04, 1, 4'h3, 32'h0000_0140);
        {parityErrEvent, addrParityEvent} = 2'b11;
        wt(4);
        `CHK({parityErrDrive, systemErrDrive}, 2'b11)
        acc(8'h04, 1, 4'h3, 32'h0);
        wt(2);
        `CHK({parityErrDrive, systemErrDrive, memClaim}, 3'b000)
        sdcf_host_model_i.access(3'h3, 0, 8'h00, 4'hf, 0, rd, ok);
        `CHK(ok, 1'b0)
    endtask : t_gates
    task automatic t_intx();
        intRequest = 1;
        for (int i = 0; i < 4; i++)
        begin
            acc(8'h88, 1, 4'h1, 32'(i) << 5);
            wt(2);
            `CHK(intxAssert, 4'h1 << i)
        end
        intSelStrap = 1;
        wt(4);
        `CHK(intxAssert, 4'h1)
        acc(8'h04, 1, 4'h3, 32'h0000_0400);
        wt(2);
        `CHK(intxAssert, 4'h0)
        // Sticky function control must survive a bus reset.
        srst = 1;
        wt(1);
        srst = 0;
        acc(8'h88, 0, 4'hf, 0);
        `CHK(rd, 32'h0000_0060)
        acc(8'h04, 0, 4'hf, 0);
        `CHK(rd, 32'h0)
    endtask : t_intx
    initial
    begin
        repeat (3) @(posedge sys_clk);
        #1;
        {srst, global_reset_n} = 2'b01;
        wt(4);
        t_regs();
        t_gates();
        t_windows();
        t_intx();
        tally_and_finish();
    end
endmodule : sdcf_config_header_tb

// ===== sdcf_host_model.sv
/* Host bridge model issuing single config cycles.
   Assumes one-cycle strobes and an ack on the next edge. */
`timescale 1ns/1ns
module sdcf_host_model (
    input  wire logic        sys_clk,
    input  wire logic [31:0] cfgRdData,
    input  wire logic        cfgAck,
    output logic             cfgSel,
    output logic [2:0]       cfgFunc,
    output logic             cfgWrite,
    output logic [7:0]       cfgAddr,
    output logic [3:0]       cfgByteEn,
    output logic [31:0]      cfgWrData
);
    initial {cfgSel, cfgFunc, cfgWrite, cfgAddr, cfgByteEn, cfgWrData} = '0;
    // One access; released lines flip so stale values never look valid.
    task automatic access(input logic [2:0] fn, input logic wr, input logic [7:0] ad,
        input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rd,
        output logic ok);
        int n;
        @(posedge sys_clk);
        #1;
        {cfgSel, cfgFunc, cfgWrite, cfgAddr, cfgByteEn, cfgWrData} = {1'b1, fn, wr, ad, be, wd};
        @(posedge sys_clk);
        #1;
        {cfgSel, cfgAddr, cfgWrData} = {1'b0, ~ad, ~wd};
        ok = 1'b0;
        rd = '0;
        for (n = 0; n < 4 && !ok; n++)
        begin
            if (cfgAck === 1'b1)
            begin
                ok = 1'b1;
                rd = cfgRdData;
            end
            else
            begin
                @(posedge sys_clk);
                #1;
            end
        end
    endtask : access
endmodule : sdcf_host_model

// ===== sdcf_pkg.sv
/*
 * Constants of the SD host function's configuration header: offsets, field
 * positions, reset values and the function number.
 * Assumes a configuration port that presents dword-aligned byte addresses.
 */
package sdcf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Function number and offsets.
    localparam logic [2:0] FUNC_NUM        = 3'h4;   // Function that owns this header.
    localparam logic [7:0] OFF_IDENT       = 8'h00;  // Maker and part identifiers.
    localparam logic [7:0] OFF_CONTROL     = 8'h04;  // Bus control word.
    localparam logic [7:0] OFF_SLOT1_BASE  = 8'h14;  // Second slot window base.
    localparam logic [7:0] OFF_SLOT2_BASE  = 8'h18;  // Third slot window base.
    localparam logic [7:0] OFF_SUBSYS      = 8'h2c;  // Subsystem identifiers, read side.
    localparam logic [7:0] OFF_FUNC_CTRL   = 8'h88;  // Function control byte.
    localparam logic [7:0] OFF_SUBSYS_ALIAS = 8'h8c; // Subsystem alias write port.
    localparam logic [7:0] OFF_TEST_PLL    = 8'h90;  // Test and PLL setup.

    ////////////////////////////////////////////////////////////////////////////
    // Bus control field positions.
    localparam int BIT_INT_DISABLE = 10;  // Interrupt line disable.
    localparam int BIT_SERR_EN     = 8;   // System error drive enable.
    localparam int BIT_PERR_EN     = 6;   // Parity response enable.
    localparam int BIT_MASTER_EN   = 2;   // Initiator enable.
    localparam int BIT_MEM_EN      = 1;   // Memory space enable.
    localparam logic [15:0] CONTROL_WMASK = 16'h0546; // Bits that store a write.
    localparam logic [15:0] CONTROL_RST   = 16'h0000; // Control after reset.

    ////////////////////////////////////////////////////////////////////////////
    // Function control, subsystem and test register layouts.
    localparam int          INT_SEL_LSB    = 5;        // Interrupt select field low bit.
    localparam logic [7:0]  FUNC_CTRL_WMASK = 8'h77;   // Bits 7 and 3 are reserved.
    localparam logic [7:0]  FUNC_CTRL_RST  = 8'h00;    // Function control after reset.
    localparam logic [31:0] SUBSYS_RST     = 32'h0000_0000; // Subsystem alias after reset.
    localparam logic [31:0] TEST_PLL_WMASK = 32'h0001_071f; // Diag, N and M fields.
    localparam logic [31:0] TEST_PLL_RST   = 32'h0000_0105; // N of 1, M of 5.
    localparam logic [31:0] SLOT_BASE_RST  = 32'h0000_0000; // Window bases after reset.

endpackage : sdcf_pkg
